/* File: shared/dcf_regs.vh */
// constants for the two-position fifo controller: width codes, depth lines, sizes
`ifndef DCF_REGS_VH
`define DCF_REGS_VH

// width selection codes
`define DCF_W_1X4K 3'h0
`define DCF_W_2X2K 3'h1
`define DCF_W_4X1K 3'h2
`define DCF_W_9X512 3'h3
`define DCF_W_18X256 3'h4
`define DCF_W_36X128 3'h5

// word sizes that go with each width code
`define DCF_BITS_1 6'h01
`define DCF_BITS_2 6'h02
`define DCF_BITS_4 6'h04
`define DCF_BITS_9 6'h09
`define DCF_BITS_18 6'h12
`define DCF_BITS_36 6'h24

// widest word and words held by one block at one bit wide
`define DCF_MAX_WIDTH 36
`define DCF_BLOCK_WORDS_LOG2 12

// depth selection lines: bit n cascades 2 to the power n+1 blocks
`define DCF_DEPTH_LINES 4
`define DCF_DEPTH_X2 4'h1
`define DCF_DEPTH_X4 4'h2
`define DCF_DEPTH_X8 4'h4
`define DCF_DEPTH_X16 4'h8

// output staging buffer
`define DCF_STAGE_DEPTH 32
`define DCF_STAGE_AW 5

`endif

/* File: src/word_fifo.v */
// small flip-flop fifo with valid/ready on both sides, used to stage read words
`default_nettype none

module word_fifo #(
  parameter WIDTH = 36,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  // clock and reset
  input wire clock,
  input wire reset,
  // fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] head_q;
  reg [AW-1:0] tail_q;
  reg [AW:0] count_q;
  wire push;
  wire pop;

  assign in_ready = (count_q != DEPTH[AW:0]);
  assign out_valid = (count_q != {(AW+1){1'b0}});
  assign out_data = mem_q[head_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always @(posedge clock) begin
    if (push) begin
      mem_q[tail_q] <= in_data;
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      head_q <= {AW{1'b0}};
      tail_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        tail_q <= (tail_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : tail_q + 1'b1;
      end
      if (pop) begin
        head_q <= (head_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : head_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

/* File: src/dual_clock_fifo_control.v */
// fifo controller: store, position counters, crossing stages, flags and read staging
`default_nettype none
`include "dcf_regs.vh"

// What this block does
// RULE_01 - each position counter carries one extra top bit to track wrap difference
// RULE_02 - empty is raised whenever read and write positions are equal
// RULE_03 - write position passes two read-side sampling stages before the empty compare
// RULE_04 - read position passes two write-side sampling stages before the full compare
// RULE_05 - writing and reading always use the same single word width
// RULE_06 - three-bit code picks 1x4k up to 36x128; codes 11x are reserved
// RULE_07 - four depth lines cascade 2, 4, 8 or 16 blocks for more depth
// RULE_08 - users should split wide words over parallel blocks rather than cascade
// RULE_09 - full when positions match except the extra top bit, which differs
// RULE_10 - positions cross as gray code so one bit changes per step
module dual_clock_fifo_control #(
  parameter ADDR_W = 16,
  parameter STAGE_DEPTH = `DCF_STAGE_DEPTH,
  parameter STAGE_AW = `DCF_STAGE_AW
) (
  // clock and reset
  input wire clock,
  input wire reset,
  // configuration lines
  input wire [2:0] width_sel,
  input wire [`DCF_DEPTH_LINES-1:0] depth_sel,
  // writer
  input wire wr_valid,
  output wire wr_ready,
  input wire [`DCF_MAX_WIDTH-1:0] wr_data,
  // reader
  output wire rd_valid,
  input wire rd_ready,
  output wire [`DCF_MAX_WIDTH-1:0] rd_data,
  // status
  output wire full,
  output wire empty,
  output wire cfg_bad
);

  localparam PW = ADDR_W + 1;
  localparam MW = `DCF_MAX_WIDTH;

  // configuration lines come from pins: two stages each before use
  reg [2:0] width_meta_q;
  reg [2:0] width_q;
  reg [`DCF_DEPTH_LINES-1:0] depth_meta_q;
  reg [`DCF_DEPTH_LINES-1:0] depth_q;

  always @(posedge clock) begin
    if (reset) begin
      width_meta_q <= 3'h0;
      width_q <= 3'h0;
      depth_meta_q <= {`DCF_DEPTH_LINES{1'b0}};
      depth_q <= {`DCF_DEPTH_LINES{1'b0}};
    end else begin
      width_meta_q <= width_sel;
      width_q <= width_meta_q;
      depth_meta_q <= depth_sel;
      depth_q <= depth_meta_q;
    end
  end

  // organisation decode; one word size serves both ports
  reg [2:0] word_shift;
  reg [5:0] word_bits;
  reg bad_code;
  always @* begin
    word_shift = 3'h0;
    word_bits = `DCF_BITS_1;
    bad_code = 1'b0;
    case (width_q) // RULE_06
      `DCF_W_1X4K: begin
        word_shift = 3'h0;
        word_bits = `DCF_BITS_1;
      end
      `DCF_W_2X2K: begin
        word_shift = 3'h1;
        word_bits = `DCF_BITS_2;
      end
      `DCF_W_4X1K: begin
        word_shift = 3'h2;
        word_bits = `DCF_BITS_4;
      end
      `DCF_W_9X512: begin
        word_shift = 3'h3;
        word_bits = `DCF_BITS_9;
      end
      `DCF_W_18X256: begin
        word_shift = 3'h4;
        word_bits = `DCF_BITS_18;
      end
      `DCF_W_36X128: begin
        word_shift = 3'h5;
        word_bits = `DCF_BITS_36;
      end
      default: begin
        bad_code = 1'b1;
      end
    endcase
  end

  // highest active depth line wins
  reg [2:0] depth_shift;
  always @* begin
    depth_shift = 3'h0;
    if (depth_q[3]) begin // RULE_07
      depth_shift = 3'h4;
    end else if (depth_q[2]) begin
      depth_shift = 3'h3;
    end else if (depth_q[1]) begin
      depth_shift = 3'h2;
    end else if (depth_q[0]) begin
      depth_shift = 3'h1;
    end
  end

  // capacity log2 is clipped to what the store can hold
  wire [4:0] cap_log2_raw;
  wire [4:0] cap_log2;
  wire [PW-1:0] cap;
  wire [PW-1:0] ptr_mask;
  wire [MW-1:0] word_mask;

  assign cap_log2_raw = 5'd`DCF_BLOCK_WORDS_LOG2 - {2'h0, word_shift} + {2'h0, depth_shift};
  assign cap_log2 = (cap_log2_raw > ADDR_W[4:0]) ? ADDR_W[4:0] : cap_log2_raw;
  assign cap = {{(PW-1){1'b0}}, 1'b1} << cap_log2;
  assign ptr_mask = (cap << 1) - 1'b1;
  assign word_mask = ~({MW{1'b1}} << word_bits); // RULE_05
  assign cfg_bad = bad_code;

  function [PW-1:0] gray2bin;
    input [PW-1:0] g;
    integer i;
    begin
      gray2bin[PW-1] = g[PW-1];
      for (i = PW - 2; i >= 0; i = i - 1) begin
        gray2bin[i] = gray2bin[i+1] ^ g[i];
      end
    end
  endfunction

  // positions: binary counters one bit wider than the address
  reg [PW-1:0] write_pointer_q; // RULE_01
  reg [PW-1:0] read_pointer_q;
  reg [PW-1:0] wr_gray_q;
  reg [PW-1:0] rd_gray_q;
  reg [PW-1:0] wr_gray_s1_q;
  reg [PW-1:0] wr_gray_s2_q;
  reg [PW-1:0] rd_gray_s1_q;
  reg [PW-1:0] rd_gray_s2_q;
  wire [PW-1:0] wr_seen;
  wire [PW-1:0] rd_seen;
  wire [PW-1:0] wr_next;
  wire [PW-1:0] rd_next;
  wire do_write;
  wire do_read;
  wire stage_ready;

  assign wr_next = (write_pointer_q + 1'b1) & ptr_mask;
  assign rd_next = (read_pointer_q + 1'b1) & ptr_mask;

  // compares use only the twice-sampled far position
  assign wr_seen = gray2bin(wr_gray_s2_q); // RULE_03
  assign rd_seen = gray2bin(rd_gray_s2_q); // RULE_04
  assign empty = (read_pointer_q == wr_seen); // RULE_02
  assign full = ((write_pointer_q ^ rd_seen) & ptr_mask) == cap; // RULE_09

  // a reserved code blocks writes so nothing lands in a bogus layout
  assign wr_ready = !full && !bad_code;
  assign do_write = wr_valid && wr_ready;
  assign do_read = !empty && stage_ready;

  always @(posedge clock) begin
    if (reset) begin
      write_pointer_q <= {PW{1'b0}};
      read_pointer_q <= {PW{1'b0}};
      wr_gray_q <= {PW{1'b0}};
      rd_gray_q <= {PW{1'b0}};
      wr_gray_s1_q <= {PW{1'b0}};
      wr_gray_s2_q <= {PW{1'b0}};
      rd_gray_s1_q <= {PW{1'b0}};
      rd_gray_s2_q <= {PW{1'b0}};
    end else begin
      if (do_write) begin
        write_pointer_q <= wr_next;
        wr_gray_q <= wr_next ^ (wr_next >> 1); // RULE_10
      end
      if (do_read) begin
        read_pointer_q <= rd_next;
        rd_gray_q <= rd_next ^ (rd_next >> 1); // RULE_10
      end
      wr_gray_s1_q <= wr_gray_q; // RULE_03
      wr_gray_s2_q <= wr_gray_s1_q;
      rd_gray_s1_q <= rd_gray_q; // RULE_04
      rd_gray_s2_q <= rd_gray_s1_q;
    end
  end

  // word store; bit ADDR_W never addresses it, but the wrap bit at cap_log2 does whenever capacity is below the full store
  reg [MW-1:0] store_q [0:(1<<ADDR_W)-1];
  wire [ADDR_W-1:0] wr_addr;
  wire [ADDR_W-1:0] rd_addr;

  assign wr_addr = write_pointer_q[ADDR_W-1:0] & ptr_mask[ADDR_W-1:0];
  assign rd_addr = read_pointer_q[ADDR_W-1:0] & ptr_mask[ADDR_W-1:0];

  always @(posedge clock) begin
    if (do_write) begin
      store_q[wr_addr] <= wr_data & word_mask; // RULE_05
    end
  end

  // staging buffer lets the reader stall without losing a fetched word
  word_fifo #(
    .WIDTH(MW),
    .DEPTH(STAGE_DEPTH),
    .AW(STAGE_AW)
  ) stage (
    .clock(clock),
    .reset(reset),
    .in_valid(!empty),
    .in_ready(stage_ready),
    .in_data(store_q[rd_addr]),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );

endmodule

`default_nettype wire

/* File: verification/dcf_props.sv */
// port assertions for the fifo controller
`default_nettype none
module dcf_props (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // config and handshakes
  input wire logic [2:0] width_sel,
  input wire logic wr_valid,
  input wire logic wr_ready,
  input wire logic rd_valid,
  input wire logic rd_ready,
  input wire logic [35:0] rd_data,
  // status
  input wire logic full,
  input wire logic empty,
  input wire logic cfg_bad
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  wire logic wr_go = wr_valid && wr_ready;
  wire logic res_code = &width_sel[2:1];
  // a write into an idle store, nothing else in flight
  sequence s_lone_wr;
    !wr_go [*3] ##1 (wr_go && empty && !rd_valid);
  endsequence
  property p_ready; wr_ready == (!full && !cfg_bad); endproperty
  a_ready: assert property (p_ready) else $error("wr_ready wrong");
  property p_reset; $fell(reset) |-> empty && !full && !rd_valid; endproperty
  a_reset: assert property (p_reset) else $error("bad reset state");
  property p_empty_lat; s_lone_wr |=> empty [*2] ##1 !empty; endproperty
  a_empty_lat: assert property (p_empty_lat) else $error("empty timing");
  property p_rd_lat; s_lone_wr |-> ##4 rd_valid; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read latency");
  property p_hold; rd_valid && !rd_ready |=> rd_valid && $stable(rd_data); endproperty
  a_hold: assert property (p_hold) else $error("read word dropped");
  // the sync stages come out of reset at zero, so skip two edges
  property p_cfg; !$past(reset) && !$past(reset, 2) |-> cfg_bad == $past(res_code, 2); endproperty
  a_cfg: assert property (p_cfg) else $error("cfg_bad wrong");
  property p_excl; !(empty && full); endproperty
  a_excl: assert property (p_excl) else $error("empty and full");
  property p_fall; $fell(empty) |-> $past(wr_go, 3); endproperty
  a_fall: assert property (p_fall) else $error("empty fell early");
endmodule
bind dual_clock_fifo_control dcf_props u_props (.clock(clock), .reset(reset),
  .width_sel(width_sel), .wr_valid(wr_valid), .wr_ready(wr_ready), .rd_valid(rd_valid),
  .rd_ready(rd_ready), .rd_data(rd_data), .full(full), .empty(empty), .cfg_bad(cfg_bad));
`default_nettype wire

/* File: verification/dcf_user.sv */
// user logic on both sides: counting writer, checking reader
`default_nettype none
module dcf_user (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // bench controls
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [35:0] mask,
  // fifo sides
  output var logic wr_valid,
  input wire logic wr_ready,
  output var logic [35:0] wr_data,
  input wire logic rd_valid,
  output var logic rd_ready,
  input wire logic [35:0] rd_data,
  // tallies
  output var int wr_n,
  output var int rd_n,
  output var int bad
);
  timeunit 1ns;
  timeprecision 1ps;
  function automatic logic [35:0] pat(input int n);
    return {~n[3:0], n};
  endfunction
  initial begin
    wr_valid = 0;
    rd_ready = 0;
  end
  always @(negedge clock) begin
    wr_valid <= wr_en;
    rd_ready <= rd_en;
    wr_data <= pat(wr_n);
  end
  always @(posedge clock) begin
    if (reset) begin
      wr_n <= 0;
      rd_n <= 0;
      bad <= 0;
    end else begin
      if (wr_valid && wr_ready) wr_n <= wr_n + 1;
      if (rd_valid && rd_ready) begin
        if (rd_data !== (pat(rd_n) & mask)) bad <= bad + 1;
        rd_n <= rd_n + 1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: verification/test_dual_clock_fifo_control.sv */
// bench for the fifo controller: widths, reserved codes, fill and drain with no cascade and at x2, x4 and x16 depth
`default_nettype none
module test_dual_clock_fifo_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0;
  logic reset = 1;
  logic [2:0] width_sel = 3'h5;
  logic [3:0] depth_sel = 4'h0;
  logic wr_en = 0;
  logic rd_en = 0;
  logic [35:0] mask = '1;
  wire logic wr_valid, wr_ready, rd_valid, rd_ready, full, empty, cfg_bad;
  wire logic [35:0] wr_data, rd_data;
  int wr_n, rd_n, bad;
  int fails = 0;
  int samples_checked = 0;
  always #2.5 clock = ~clock;
  dual_clock_fifo_control uut (.clock(clock), .reset(reset), .width_sel(width_sel),
    .depth_sel(depth_sel), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data), .full(full),
    .empty(empty), .cfg_bad(cfg_bad));
  dcf_user user (.clock(clock), .reset(reset), .wr_en(wr_en), .rd_en(rd_en), .mask(mask),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .rd_data(rd_data), .wr_n(wr_n), .rd_n(rd_n), .bad(bad));
  task chk(input logic [35:0] got, input logic [35:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task print_verdict;
    $display("checks=%0d fails=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // config only changes under reset, then the syncs get time to settle
  task restart(input logic [2:0] code, input logic [3:0] dep, input logic [35:0] m);
    @(negedge clock);
    reset = 1;
    wr_en = 0;
    rd_en = 0;
    width_sel = code;
    depth_sel = dep;
    mask = m;
    repeat (8) @(negedge clock);
    reset = 0;
    repeat (3) @(negedge clock);
  endtask
  task drain;
    wr_en = 0;
    rd_en = 1;
    for (int i = 0; i < 3000 && (rd_n != wr_n || rd_valid); i++) @(negedge clock);
    chk(36'(rd_n), 36'(wr_n));
    chk(36'(bad), 36'h0);
    chk(empty, 1'b1);
  endtask
  task t_widths;
    int bits[8] = '{1, 2, 4, 9, 18, 36, 36, 36};
    for (int c = 0; c < 8; c++) begin
      restart(c[2:0], 4'h0, (36'h1 << bits[c]) - 36'h1);
      wr_en = 1;
      rd_en = 1;
      repeat (24) @(negedge clock);
      drain;
      chk(cfg_bad, c > 5);
      chk(36'(wr_n > 0), 36'(c < 6));
    end
  endtask
  task t_fill(input logic [3:0] dep, input int cap);
    int n;
    restart(3'h5, dep, '1);
    wr_en = 1;
    for (n = 0; n < 4000 && wr_ready; n++) @(negedge clock);
    chk(36'(wr_n), 36'(cap + 32));
    chk(full, 1'b1);
    rd_en = 1;
    for (n = 0; n < 8 && !wr_ready; n++) @(negedge clock);
    chk(36'(n < 8), 36'h1);
    drain;
  endtask
  initial begin
    t_widths;
    t_fill(4'h0, 128);
    t_fill(4'h1, 256);
    t_fill(4'h3, 512);
    t_fill(4'h8, 2048);
    print_verdict;
  end
  initial begin
    // all scenarios need about 7000 cycles; this allows roughly three times that
    #100us;
    fails++;
    print_verdict;
  end
endmodule
`default_nettype wire
